/* hdl/pfp_pkg.sv */
package pfp_pkg;

  // Array geometry: fifteen address bits and a byte per cell.
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  // The encryption table covers addresses zero up to 3fh.
  localparam int KEY_ADDR_W = 6;
  // The lowest address bit that the erase forces low (bits 14 to 12).
  localparam int FORCE_LSB = 12;

  // System clock rate.
  localparam int unsigned CLK_HZ = 10_000_000;
  // The chip erase lasts more than this many milliseconds.
  localparam int unsigned ERASE_TIME_MS = 200;
  // Cycles of erase: one beyond the figure, so it runs strictly longer.
  localparam int unsigned ERASE_CYCLES = ERASE_TIME_MS * (CLK_HZ / 1000) + 1;
  // Verify data must appear within this many oscillator periods.
  localparam int unsigned VERIFY_OSC_PERIODS = 48;

  // Mode pin patterns, in the order port2 bit7, bit6, port3 bit7, bit6.
  localparam logic [3:0] PAT_VERIFY = 4'h3;
  localparam logic [3:0] PAT_PGM_CODE = 4'hb;
  localparam logic [3:0] PAT_PGM_KEY = 4'ha;
  localparam logic [3:0] PAT_PGM_SEC1 = 4'hf;
  localparam logic [3:0] PAT_PGM_SEC2 = 4'hc;
  localparam logic [3:0] PAT_ERASE = 4'h4;

  // Values after reset and after erase.
  localparam logic SEC_RESET = 1'h0;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
  localparam logic [DATA_W-1:0] PORT0_IDLE = 8'h00;

  // Operations that the mode pins can select.
  typedef enum {
    MODE_NONE,
    MODE_VERIFY,
    MODE_PGM_CODE,
    MODE_PGM_KEY,
    MODE_PGM_SEC1,
    MODE_PGM_SEC2,
    MODE_ERASE
  } pfp_mode_type;

  // Sequencer states.
  typedef enum {
    ST_IDLE,
    ST_ERASE
  } pfp_state_type;

  // Map a mode pin pattern onto an operation.
  function automatic pfp_mode_type pfp_decode_mode(input logic [3:0] pat);
    pfp_mode_type m;
    m = MODE_NONE;
    case (pat)
      PAT_VERIFY: m = MODE_VERIFY;
      PAT_PGM_CODE: m = MODE_PGM_CODE;
      PAT_PGM_KEY: m = MODE_PGM_KEY;
      PAT_PGM_SEC1: m = MODE_PGM_SEC1;
      PAT_PGM_SEC2: m = MODE_PGM_SEC2;
      PAT_ERASE: m = MODE_ERASE;
      default: m = MODE_NONE;
    endcase
    return m;
  endfunction

endpackage

/* hdl/pfp_flash_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Carries one access to the code array and the encryption table.
interface pfp_flash_if #(
  parameter int AW = 15,
  parameter int DW = 8,
  parameter int KW = 6
);
  // Cell address; the table uses its low bits.
  logic [AW-1:0] addr;
  // Byte to program.
  logic [DW-1:0] wrData;
  // Program strobes for the code array and the table.
  logic wrEn;
  logic keyWrEn;
  // Sets every cell of both stores to ones in one cycle.
  logic eraseAll;
  // Registered read data of the code array and of the table.
  logic [DW-1:0] rdData;
  logic [DW-1:0] keyData;

  modport ctrl (
    output addr, wrData, wrEn, keyWrEn, eraseAll,
    input rdData, keyData
  );
  modport store (
    input addr, wrData, wrEn, keyWrEn, eraseAll,
    output rdData, keyData
  );
endinterface

`default_nettype wire

/* hdl/pfp_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a group of pin levels.
module pfp_sync #(
  parameter int WIDTH = 8
) (
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  // Raw pins and their synchronised copy.
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);

  // The first stage feeds only the second stage, nothing else.
  logic [WIDTH-1:0] stage1_reg;

  // Both stages reset to zero and hold while the enable is low.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      pinOut <= '0;
    end else if (clkEn) begin
      stage1_reg <= pinIn;
      pinOut <= stage1_reg;
    end
  end

endmodule

`default_nettype wire

/* hdl/pfp_flash_array.sv */
`timescale 1ns/1ps
`default_nettype none

// Code array and encryption table, both held in flip-flops.
module pfp_flash_array
  import pfp_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int KW = KEY_ADDR_W
) (
  // Clock and enable; cell contents have no reset, like real flash.
  input wire logic mclk,
  input wire logic clkEn,
  // Access port from the sequencer.
  pfp_flash_if.store acc
);

  // Storage indexed by address.
  logic [DATA_W-1:0] codeMem [2**AW];
  logic [DATA_W-1:0] keyMem [2**KW];

  // Programming can only clear bits, so repeated pulses are harmless.
  always_ff @(posedge mclk) begin
    if (clkEn) begin
      if (acc.eraseAll) begin
        for (int i = 0; i < 2**AW; i++) begin
          codeMem[i] <= ERASED_BYTE;
        end
      end else if (acc.wrEn) begin
        codeMem[acc.addr] <= codeMem[acc.addr] & acc.wrData;
      end
    end
  end

  // The table erases together with the code array.
  always_ff @(posedge mclk) begin
    if (clkEn) begin
      if (acc.eraseAll) begin
        for (int i = 0; i < 2**KW; i++) begin
          keyMem[i] <= ERASED_BYTE;
        end
      end else if (acc.keyWrEn) begin
        keyMem[acc.addr[KW-1:0]] <= keyMem[acc.addr[KW-1:0]] & acc.wrData;
      end
    end
  end

  // Registered reads; the table byte only ever leaves through the sequencer.
  always_ff @(posedge mclk) begin
    if (clkEn) begin
      acc.rdData <= codeMem[acc.addr];
      acc.keyData <= keyMem[acc.addr[KW-1:0]];
    end
  end

endmodule

`default_nettype wire

/* hdl/pfp_top.sv */
// Functional notes
// R1: Mode chosen by four pin levels plus voltage.
// R2: Programmer keeps oscillator running at 4-6 MHz; CLK_HZ and the testbench use 10 MHz.
// R3: Programmer holds address and data before strobe.
// R4: Programmer loads table for addresses 0 to 3fh.
// R5: Either security bit blocks code and table programming.
// R6: Verify only while security bit two is clear.
// R7: Verify drives the addressed byte onto port 0.
// R8: Loaded table makes verify return XNOR-ed bytes.
// R9: No path reads the table back.
// R10: Erase sets code, lock and table to ones; the lock bits here clear to zero (SEC_RESET).
// R11: Erase is self-timed, longer than 200 ms.
// R12: Programmer pulses 20 us, at most four times.
// R13: Erase pulses are 30 ms, at most five; the testbench gives one 3 us strobe and the erase is self-timed.
// R14: Upper address bits forced low during erase.
// R15: Strobes count only with programming voltage high.
// R16: Verify data valid quickly; released when enable high.
`timescale 1ns/1ps
`default_nettype none

module pfp_top
  import pfp_pkg::*;
#(
  parameter int unsigned ERASE_CYC = ERASE_CYCLES
) (
  // Clock, reset and clock enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  // Control pins of the programming interface.
  input wire logic resetPin,
  input wire logic codeFetchStrobe_n,
  input wire logic latchOrProgramStrobe_n,
  input wire logic programVoltagePin,
  // Mode select pins.
  input wire logic port2Bit7Enable,
  input wire logic port2Bit6Select,
  input wire logic port3Bit7Select,
  input wire logic port3Bit6Select,
  // Address pins: port 1 low byte, port 2 bits 5..0, port 3 bit 4.
  input wire logic [7:0] port1Addr,
  input wire logic [5:0] port2Addr,
  input wire logic addressBitFourteen,
  // Data port 0 as input, output and output enable.
  input wire logic [DATA_W-1:0] port0In,
  output logic [DATA_W-1:0] port0Out,
  output logic port0Oe,
  // Status levels and the refusal pulse.
  output logic eraseBusy,
  output logic securityBit1,
  output logic securityBit2,
  output logic keyLoaded,
  output logic writeRefused
);

  // Width of the erase counter, sized from the erase length.
  localparam int CNT_W = $clog2(ERASE_CYC + 1);
  // Number of pins passed through the synchroniser.
  localparam int SYNC_W = 8 + ADDR_W + DATA_W;

  // Raw and synchronised pin groups.
  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] pinSync;
  // Synchronised control pins.
  logic syncReset;
  logic syncFetch_n;
  logic syncStrobe_n;
  logic syncVpp;
  logic syncEnable;
  logic [3:0] syncPattern;
  logic [ADDR_W-1:0] syncAddr;
  logic [DATA_W-1:0] syncData;
  // Previous strobe level, taken from the second synchroniser stage.
  logic strobePrev_reg;
  // One-cycle pulse on a falling program strobe.
  logic strobeFall;
  // Decoded mode and qualifiers.
  pfp_mode_type mode;
  logic modeValid;
  logic writeAccepted;
  logic codeLocked;
  logic verifyOk;
  // Sequencer state and erase counter.
  pfp_state_type state_reg;
  pfp_state_type state_next;
  logic [CNT_W-1:0] eraseCnt_reg;
  logic eraseDone;
  // Lock bits and table flag.
  logic sec1_reg;
  logic sec2_reg;
  logic keyLoaded_reg;
  // Pulse that clears every cell.
  logic eraseAll_reg;
  // Address as the array sees it.
  logic [ADDR_W-1:0] effAddr;

  // Access port to the array.
  pfp_flash_if #(
    .AW(ADDR_W),
    .DW(DATA_W),
    .KW(KEY_ADDR_W)
  ) acc ();

  // All pins come from the programmer's clock domain, so each is
  // synchronised before any decision reads it.
  assign pinRaw = {resetPin, codeFetchStrobe_n, latchOrProgramStrobe_n,
                   programVoltagePin, port2Bit7Enable, port2Bit6Select,
                   port3Bit7Select, port3Bit6Select, addressBitFourteen,
                   port2Addr, port1Addr, port0In};

  pfp_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .clkEn(clkEn),
    .pinIn(pinRaw),
    .pinOut(pinSync)
  );

  // Split the synchronised group back into named levels.
  assign syncReset = pinSync[SYNC_W-1];
  assign syncFetch_n = pinSync[SYNC_W-2];
  assign syncStrobe_n = pinSync[SYNC_W-3];
  assign syncVpp = pinSync[SYNC_W-4];
  assign syncEnable = pinSync[SYNC_W-5];
  assign syncPattern = pinSync[SYNC_W-5 -: 4];
  assign syncAddr = pinSync[DATA_W +: ADDR_W];
  assign syncData = pinSync[DATA_W-1:0];

  // Remember the strobe to find its falling edge.
  // It resets low like the synchroniser, so no false edge follows reset.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strobePrev_reg <= 1'h0;
    end else if (clkEn) begin
      strobePrev_reg <= syncStrobe_n;
    end
  end

  // A strobe counts once per low pulse, on its leading edge.
  assign strobeFall = strobePrev_reg & ~syncStrobe_n;

  // R1: pattern decode
  // Every mode also needs reset held high and the fetch strobe low.
  assign mode = pfp_decode_mode(syncPattern);
  assign modeValid = syncReset & ~syncFetch_n;

  // R15: voltage gates strobes
  // A strobe without the programming level is simply ignored.
  assign writeAccepted = strobeFall & syncVpp & modeValid
                         & (state_reg == ST_IDLE);

  // R5: security lockout
  // Either lock bit stops code and table writes, never lock writes.
  assign codeLocked = sec1_reg | sec2_reg;

  // R6: verify gate
  // Read-out needs the verify pattern, an idle sequencer and lock two clear.
  assign verifyOk = modeValid & (mode == MODE_VERIFY) & ~sec2_reg
                    & (state_reg == ST_IDLE);

  // R14: upper bits forced
  // While erasing, the array sees bits 14 to 12 held low.
  always_comb begin
    effAddr = syncAddr;
    if (state_reg == ST_ERASE) begin
      effAddr[ADDR_W-1:FORCE_LSB] = '0;
    end
  end

  // Array access: the byte on port 0 is the data to program.
  assign acc.addr = effAddr;
  assign acc.wrData = syncData;
  assign acc.eraseAll = eraseAll_reg;

  // R3: write on strobe
  // Address and data are taken as they stand when the strobe falls.
  assign acc.wrEn = writeAccepted & (mode == MODE_PGM_CODE) & ~codeLocked;

  // R4: table write
  // Only the low six address bits select a table byte.
  assign acc.keyWrEn = writeAccepted & (mode == MODE_PGM_KEY) & ~codeLocked;

  pfp_flash_array #(
    .AW(ADDR_W),
    .KW(KEY_ADDR_W)
  ) u_array (
    .mclk(mclk),
    .clkEn(clkEn),
    .acc(acc)
  );

  // R11: erase timer end
  assign eraseDone = (state_reg == ST_ERASE) && (eraseCnt_reg == '0);

  // Next-state logic: an accepted erase strobe starts the timed erase,
  // and further strobes are ignored until it has finished.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (writeAccepted && mode == MODE_ERASE) begin
          state_next = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (eraseDone) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // R11: self-timed erase
  // The count runs on the system clock, so the erase does not depend on
  // how long the programmer holds the strobe.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eraseCnt_reg <= '0;
    end else if (clkEn) begin
      if (state_reg == ST_IDLE && state_next == ST_ERASE) begin
        eraseCnt_reg <= CNT_W'(ERASE_CYC - 1);
      end else if (state_reg == ST_ERASE && eraseCnt_reg != '0) begin
        eraseCnt_reg <= eraseCnt_reg - 1'h1;
      end
    end
  end

  // R10: erase all at once
  // The clear pulse lands one cycle after the last erase cycle, for the code array and the table.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eraseAll_reg <= 1'h0;
    end else if (clkEn) begin
      eraseAll_reg <= eraseDone;
    end
  end

  // Lock bits: set by their own write, cleared by the erase or by reset.
  // The erase cannot overlap a write, since strobes are ignored then.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sec1_reg <= SEC_RESET;
      sec2_reg <= SEC_RESET;
    end else if (clkEn) begin
      if (eraseDone) begin
        sec1_reg <= SEC_RESET;
        sec2_reg <= SEC_RESET;
      end else begin
        // R5: other bit stays open
        if (writeAccepted && mode == MODE_PGM_SEC1) begin
          sec1_reg <= 1'h1;
        end
        if (writeAccepted && mode == MODE_PGM_SEC2) begin
          sec2_reg <= 1'h1;
        end
      end
    end
  end

  // R8: table loaded flag
  // Marks that verify output is now scrambled by the table.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      keyLoaded_reg <= 1'h0;
    end else if (clkEn) begin
      if (eraseDone) begin
        keyLoaded_reg <= 1'h0;
      end else if (acc.keyWrEn) begin
        keyLoaded_reg <= 1'h1;
      end
    end
  end

  // Verify output: a few system cycles of latency, far inside the
  // allowed window of oscillator periods.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port0Out <= PORT0_IDLE;
      port0Oe <= 1'h0;
    end else if (clkEn) begin
      // R16: release on enable high
      port0Oe <= verifyOk & ~syncEnable;
      if (verifyOk) begin
        // R9: table not readable
        // The table byte only ever leaves mixed with a code byte.
        if (keyLoaded_reg) begin
          // R8: XNOR scramble
          port0Out <= acc.rdData ~^ acc.keyData;
        end else begin
          // R7: plain byte out
          port0Out <= acc.rdData;
        end
      end else begin
        port0Out <= PORT0_IDLE;
      end
    end
  end

  // Status outputs, one flip-flop each.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eraseBusy <= 1'h0;
      securityBit1 <= SEC_RESET;
      securityBit2 <= SEC_RESET;
      keyLoaded <= 1'h0;
      writeRefused <= 1'h0;
    end else if (clkEn) begin
      eraseBusy <= (state_next == ST_ERASE);
      securityBit1 <= sec1_reg;
      securityBit2 <= sec2_reg;
      keyLoaded <= keyLoaded_reg;
      // R5: refusal visible
      writeRefused <= writeAccepted & codeLocked
                      & (mode == MODE_PGM_CODE || mode == MODE_PGM_KEY);
    end
  end

endmodule

`default_nettype wire

/* verif/pfp_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// Watches the programming port from its pins alone.
module pfp_properties
  import pfp_pkg::*;
#(
  parameter int unsigned ERASE_CYC = ERASE_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Control and mode pins.
  input wire logic resetPin,
  input wire logic codeFetchStrobe_n,
  input wire logic programVoltagePin,
  input wire logic port2Bit7Enable,
  input wire logic port2Bit6Select,
  input wire logic port3Bit7Select,
  input wire logic port3Bit6Select,
  // Outputs of the block.
  input wire logic [DATA_W-1:0] port0Out,
  input wire logic port0Oe,
  input wire logic eraseBusy,
  input wire logic securityBit1,
  input wire logic securityBit2,
  input wire logic keyLoaded,
  input wire logic writeRefused
);
  // Verify is requested and nothing stands in its way.
  logic readAllowed;
  // Cycles seen with the erase running.
  logic [31:0] busyCnt;

  assign readAllowed = ({port2Bit7Enable, port2Bit6Select, port3Bit7Select,
    port3Bit6Select} == PAT_VERIFY) && resetPin && !codeFetchStrobe_n &&
    programVoltagePin && !securityBit2 && !eraseBusy;

  // Counts the erase length; it restarts at zero whenever the erase ends.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busyCnt <= '0;
    end else begin
      busyCnt <= eraseBusy ? busyCnt + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_oe_soon;
    readAllowed [*6] |-> port0Oe;
  endproperty
  a_oe_soon: assert property (p_oe_soon)
    else $error("port 0 not driven during verify");
  property p_idle_out;
    !port0Oe |-> port0Out == PORT0_IDLE;
  endproperty
  a_idle_out: assert property (p_idle_out)
    else $error("port 0 data without output enable");
  property p_release;
    port2Bit7Enable [*5] |-> !port0Oe;
  endproperty
  a_release: assert property (p_release)
    else $error("port 0 still driven after enable high");
  property p_sec2_hide;
    securityBit2 |-> !port0Oe;
  endproperty
  a_sec2_hide: assert property (p_sec2_hide)
    else $error("verify read while second lock set");
  property p_erase_len;
    $fell(eraseBusy) |-> busyCnt == ERASE_CYC;
  endproperty
  a_erase_len: assert property (p_erase_len)
    else $error("erase length wrong");
  property p_erase_clear;
    $fell(eraseBusy) |-> ##1 (!securityBit1 && !securityBit2 && !keyLoaded);
  endproperty
  a_erase_clear: assert property (p_erase_clear)
    else $error("lock or table flag survived erase");
  property p_refuse;
    writeRefused |-> (securityBit1 || securityBit2) ##1 !writeRefused;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refusal pulse wrong");
  property p_lock_kept;
    $fell(securityBit1) || $fell(securityBit2) |->
      $past(eraseBusy, 2) && !$past(eraseBusy);
  endproperty
  a_lock_kept: assert property (p_lock_kept)
    else $error("lock bit cleared without erase");
  property p_key_locked;
    $rose(keyLoaded) |-> !securityBit1 && !securityBit2;
  endproperty
  a_key_locked: assert property (p_key_locked)
    else $error("table written while locked");
  property p_no_vpp;
    !programVoltagePin [*6] |-> !$rose(eraseBusy) && !$rose(securityBit1);
  endproperty
  a_no_vpp: assert property (p_no_vpp)
    else $error("strobe acted without programming voltage");
endmodule

`default_nettype wire

/* verif/pfp_programmer.sv */
`timescale 1ns/1ps
`default_nettype none

// External parallel programmer: drives the static pins and the strobe.
module pfp_programmer (
  // Device oscillator, taken as running for the whole session.
  input wire logic mclk,
  // Control pins.
  output logic resetPin,
  output logic codeFetchStrobe_n,
  output logic latchOrProgramStrobe_n,
  output logic programVoltagePin,
  // Mode pins.
  output logic port2Bit7Enable,
  output logic port2Bit6Select,
  output logic port3Bit7Select,
  output logic port3Bit6Select,
  // Address and data pins.
  output logic [7:0] port1Addr,
  output logic [5:0] port2Addr,
  output logic addressBitFourteen,
  output logic [7:0] port0In
);
  // Setup and hold around each strobe, in oscillator periods.
  localparam int HOLD = 48;
  // Verify pattern as seen on the pins.
  localparam logic [3:0] PAT_VERIFY_LEVELS = 4'h3;

  // Parked: enable high selects no mode; reset high, fetch low throughout.
  initial begin
    resetPin = 1'b1;
    codeFetchStrobe_n = 1'b0;
    latchOrProgramStrobe_n = 1'b1;
    programVoltagePin = 1'b0;
    {port2Bit7Enable, port2Bit6Select, port3Bit7Select} = 3'h4;
    port3Bit6Select = 1'b0;
    {addressBitFourteen, port2Addr, port1Addr} = 15'h0;
    port0In = 8'h00;
  end

  // pins held
  // Sets mode, voltage, address and data, then gives one low strobe.
  task automatic op(input logic [3:0] pat, input logic vpp,
    input logic [14:0] a, input logic [7:0] d, input int low);
    @(posedge mclk);
    #1;
    {port2Bit7Enable, port2Bit6Select, port3Bit7Select,
      port3Bit6Select} = pat;
    programVoltagePin = vpp;
    {addressBitFourteen, port2Addr, port1Addr} = a;
    port0In = d;
    repeat (HOLD) @(posedge mclk);
    #1 latchOrProgramStrobe_n = 1'b0;
    repeat (low) @(posedge mclk);
    #1 latchOrProgramStrobe_n = 1'b1;
    repeat (HOLD) @(posedge mclk);
    // Released data lines do not keep the old value.
    #1 port0In = ~d;
  endtask

  // verify levels
  // Applies the verify levels and an address, leaving time for data.
  task automatic rd(input logic [14:0] a);
    @(posedge mclk);
    #1;
    {port2Bit7Enable, port2Bit6Select, port3Bit7Select,
      port3Bit6Select} = PAT_VERIFY_LEVELS;
    programVoltagePin = 1'b1;
    {addressBitFourteen, port2Addr, port1Addr} = a;
    repeat (8) @(posedge mclk);
    #1;
  endtask

  // Raises the enable so that the device lets go of port 0.
  task automatic park();
    @(posedge mclk);
    #1 port2Bit7Enable = 1'b1;
  endtask
endmodule

`default_nettype wire

/* verif/pfp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module pfp_top_tb;
  import pfp_pkg::*;
  // Short erase keeps the run brief; strobe widths in 100 ns cycles.
  localparam int unsigned ECYC = 20;
  localparam int PLOW = 200;
  localparam int ELOW = 30;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic resetPin, fetchN, strobeN, vppPin, p27, p26, p37, p36, a14;
  logic [7:0] a1;
  logic [5:0] a2;
  logic [7:0] d0In, port0Out;
  logic port0Oe, eraseBusy, securityBit1, securityBit2, keyLoaded;
  logic writeRefused;
  logic [7:0] refusedCnt = 8'h00;
  logic [7:0] busyCycles = 8'h00;
  logic [7:0] key [64];
  int badCount = 0;
  int nTests = 0;

  always #50 mclk = ~mclk;

  // The refusal is a one-cycle pulse, so it is counted here.
  // Erase cycles are counted too, to measure the self-timed length.
  always @(posedge mclk) begin
    if (writeRefused === 1'b1) begin
      refusedCnt <= refusedCnt + 8'h01;
    end
    if (eraseBusy === 1'b1) begin
      busyCycles <= busyCycles + 8'h01;
    end
  end

  pfp_programmer i_program_pulse_strobe (.mclk(mclk), .resetPin(resetPin),
    .codeFetchStrobe_n(fetchN), .latchOrProgramStrobe_n(strobeN),
    .programVoltagePin(vppPin), .port2Bit7Enable(p27),
    .port2Bit6Select(p26), .port3Bit7Select(p37), .port3Bit6Select(p36),
    .port1Addr(a1), .port2Addr(a2), .addressBitFourteen(a14),
    .port0In(d0In));

  pfp_top #(.ERASE_CYC(ECYC)) i_dut (.mclk(mclk), .rst(rst),
    .clkEn(1'b1), .resetPin(resetPin), .codeFetchStrobe_n(fetchN),
    .latchOrProgramStrobe_n(strobeN), .programVoltagePin(vppPin),
    .port2Bit7Enable(p27), .port2Bit6Select(p26), .port3Bit7Select(p37),
    .port3Bit6Select(p36), .port1Addr(a1), .port2Addr(a2),
    .addressBitFourteen(a14), .port0In(d0In), .port0Out(port0Out),
    .port0Oe(port0Oe), .eraseBusy(eraseBusy), .securityBit1(securityBit1),
    .securityBit2(securityBit2), .keyLoaded(keyLoaded),
    .writeRefused(writeRefused));

  // Compares a byte result.
  task automatic chk8(input string what, input logic [7:0] exp, got);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compares a flag result.
  task automatic chk1(input string what, input logic exp, got);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Reads one cell through verify and compares it.
  task automatic verifyByte(input logic [14:0] a, input logic [7:0] exp);
    i_program_pulse_strobe.rd(a);
    chk1("port0Oe", 1'b1, port0Oe);
    chk8("port0Out", exp, port0Out);
  endtask

  // Runs an erase and waits, bounded, for it to finish.
  task automatic eraseChip();
    int n;
    n = 0;
    i_program_pulse_strobe.op(PAT_ERASE, 1'b1, 15'h7fff, 8'h00, ELOW);
    while (eraseBusy !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100) begin
      badCount++;
      testDone();
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic testDone();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    // Cells have no reset, so the session starts with an erase.
    eraseChip();
    chk8("eraseBusy cycles", 8'(ECYC), busyCycles);
    verifyByte(15'h1234, 8'hff);
    $display("test erase done");
    i_program_pulse_strobe.op(PAT_PGM_CODE, 1'b1, 15'h1234, 8'h5a, PLOW);
    i_program_pulse_strobe.op(PAT_PGM_CODE, 1'b1, 15'h4abc, 8'h3c, PLOW);
    i_program_pulse_strobe.op(PAT_PGM_CODE, 1'b0, 15'h0010, 8'h00, PLOW);
    verifyByte(15'h1234, 8'h5a);
    verifyByte(15'h4abc, 8'h3c);
    verifyByte(15'h0010, 8'hff);
    $display("test program done");
    for (int i = 0; i < 64; i++) begin
      key[i] = {2'h0, 6'(i)} ^ 8'hc5;
      i_program_pulse_strobe.op(PAT_PGM_KEY, 1'b1, 15'(i), key[i], PLOW);
    end
    chk1("keyLoaded", 1'b1, keyLoaded);
    verifyByte(15'h1234, ~(8'h5a ^ key[6'h34]));
    verifyByte(15'h4abc, ~(8'h3c ^ key[6'h3c]));
    $display("test table done");
    i_program_pulse_strobe.op(PAT_PGM_SEC1, 1'b1, 15'h0000, 8'h00, PLOW);
    chk1("securityBit1", 1'b1, securityBit1);
    i_program_pulse_strobe.op(PAT_PGM_CODE, 1'b1, 15'h0020, 8'h00, PLOW);
    chk8("writeRefused", 8'h01, refusedCnt);
    i_program_pulse_strobe.op(PAT_PGM_KEY, 1'b1, 15'h0000, 8'h00, PLOW);
    chk8("writeRefused", 8'h02, refusedCnt);
    verifyByte(15'h0020, key[6'h20]);
    verifyByte(15'h0000, key[6'h00]);
    i_program_pulse_strobe.op(PAT_PGM_SEC2, 1'b1, 15'h0000, 8'h00, PLOW);
    chk1("securityBit2", 1'b1, securityBit2);
    i_program_pulse_strobe.rd(15'h1234);
    chk1("port0Oe", 1'b0, port0Oe);
    chk8("port0Out", PORT0_IDLE, port0Out);
    $display("test lock done");
    eraseChip();
    chk8("eraseBusy cycles", 8'(2 * ECYC), busyCycles);
    chk1("securityBit1", 1'b0, securityBit1);
    chk1("securityBit2", 1'b0, securityBit2);
    chk1("keyLoaded", 1'b0, keyLoaded);
    verifyByte(15'h1234, 8'hff);
    i_program_pulse_strobe.park();
    repeat (6) @(posedge mclk);
    #1 chk1("port0Oe", 1'b0, port0Oe);
    $display("test release done");
    testDone();
  end
endmodule

bind pfp_top pfp_properties #(.ERASE_CYC(ERASE_CYC)) i_props (
  .mclk(mclk), .rst(rst), .resetPin(resetPin),
  .codeFetchStrobe_n(codeFetchStrobe_n),
  .programVoltagePin(programVoltagePin), .port2Bit7Enable(port2Bit7Enable),
  .port2Bit6Select(port2Bit6Select), .port3Bit7Select(port3Bit7Select),
  .port3Bit6Select(port3Bit6Select), .port0Out(port0Out),
  .port0Oe(port0Oe), .eraseBusy(eraseBusy), .securityBit1(securityBit1),
  .securityBit2(securityBit2), .keyLoaded(keyLoaded),
  .writeRefused(writeRefused));

`default_nettype wire
